// file: pkg/lmc_pkg.sv
// lmc_pkg: constants and carrier types for the lane-masked serdes control.
// assumes one 100 MHz management clock and a decoded register access port.
package lmc_pkg;

  // ****************************************************************
  // geometry and addressing
  // ****************************************************************
  localparam int LMC_LANES = 4;
  localparam logic [4:0] LMC_DEV_ADDR = 5'h1e;
  localparam logic [15:0] LMC_REG_CTRL1 = 16'h0006;
  localparam logic [15:0] LMC_REG_CTRL2 = 16'h0007;
  localparam logic [15:0] LMC_REG_CTRL3 = 16'h0008;
  localparam logic [15:0] LMC_REG_CHCTL = 16'h0009;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int LMC_SEL_MSB = 15;
  localparam int LMC_SEL_LSB = 12;
  localparam int LMC_BW_MSB = 9;
  localparam int LMC_BW_LSB = 8;
  localparam int LMC_PLL_EN = 4;
  localparam int LMC_MPY_MSB = 3;
  localparam int LMC_MPY_LSB = 0;
  localparam logic [15:0] LMC_CTRL1_RST = 16'hf115;
  localparam logic [15:0] LMC_CTRL2_RST = 16'hdc04;
  localparam logic [15:0] LMC_CTRL3_RST = 16'h0000;
  localparam logic [15:0] LMC_CHCTL_RST = 16'h0000;
  localparam logic [15:0] LMC_RD_NONE = 16'h0000;
  localparam logic [1:0] LMC_BW_NO_CLEANER = 2'h1;
  localparam logic [1:0] LMC_BW_CLEANER = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    LMC_LREG_NONE  = 2'b00,
    LMC_LREG_CTRL2 = 2'b01,
    LMC_LREG_CTRL3 = 2'b10,
    LMC_LREG_CHCTL = 2'b11
  } lmc_lreg_t;

  typedef struct packed {
    logic [15:0] ctrl2;
    logic [15:0] ctrl3;
    logic [15:0] chctl;
  } lmc_lane_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lmc_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } lmc_rsp_t;

  typedef struct packed {
    logic on;
    logic [1:0] loop_bw;
    logic bw_rsvd;
    logic [3:0] mpy;
    logic [7:0] factor_x2;
    logic mpy_rsvd;
  } lmc_pll_t;

  typedef struct packed {
    logic [15:0] ctrl1;
    lmc_rsp_t rsp;
    logic [2:0] pd_sync;
    logic pd_n_level;
    lmc_pll_t pll;
  } lmc_state_t;

  // multiplier factor doubled so that 12.5x stays an integer; 0 = reserved
  function automatic logic [7:0] lmc_mpy_factor_x2(input logic [3:0] code);
    logic [7:0] f;
    f = 8'h00;
    case (code)
      4'h0: f = 8'd8;
      4'h1: f = 8'd10;
      4'h2: f = 8'd12;
      4'h4: f = 8'd16;
      4'h5: f = 8'd20;
      4'h6: f = 8'd24;
      4'h7: f = 8'd25;
      4'h8: f = 8'd30;
      4'h9: f = 8'd40;
      4'ha: f = 8'd50;
      4'hd: f = 8'd100;
      4'he: f = 8'd130;
      default: f = 8'h00;
    endcase
    return f;
  endfunction

endpackage

// file: design/lmc_lane_bank.sv
// lmc_lane_bank: stored settings of one low-speed serdes lane.
// assumes the caller has already gated the write with the lane mask.
`timescale 1ns/100ps
module lmc_lane_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // gated write
  input wire logic wr_en,
  input wire lmc_pkg::lmc_lreg_t wsel,
  input wire logic [15:0] wdata,
  // stored settings
  output lmc_pkg::lmc_lane_t settings
);
  import lmc_pkg::*;

  lmc_lane_t cur;
  lmc_lane_t next_cur;

  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      case (wsel)
        LMC_LREG_CTRL2: next_cur.ctrl2 = wdata;
        LMC_LREG_CTRL3: next_cur.ctrl3 = wdata;
        LMC_LREG_CHCTL: next_cur.chctl = wdata;
        default: next_cur = cur;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // (RULE11) lane reset values
      cur <= '{ctrl2: LMC_CTRL2_RST, ctrl3: LMC_CTRL3_RST,
               chctl: LMC_CHCTL_RST};
    end else begin
      cur <= next_cur;
    end
  end

  assign settings = cur;

endmodule

// file: design/lmc_lane_ctrl.sv
// lmc_lane_ctrl: lane-select and low-speed pll control register with
// four lane-masked setting banks behind it.
// assumes decoded management accesses on clk and a raw power-down pin.
//
// Overview of operation
// (RULE1) lane mask bits 15:12 gate lane writes
// (RULE2) one write updates every selected lane
// (RULE3) reads return the one-hot selected lane
// (RULE4) software keeps mask one-hot when reading
// (RULE5) loop bandwidth bits 9:8 reset 01
// (RULE6) bit 4 enables pll, resets one
// (RULE7) power-down pin or global bit kill pll
// (RULE8) multiplier bits 3:0 reset 0101
// (RULE9) multiplier codes decode to listed factors
// (RULE10) reserved bits read/write, reset zero
// (RULE11) second lane register 0x0007 resets 0xdc04
// (RULE12) control register 0x0006 resets 0xf115
// (RULE13) zero mask writes change no lane
`timescale 1ns/100ps
module lmc_lane_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management register access
  input wire lmc_pkg::lmc_req_t mgmt_req,
  output lmc_pkg::lmc_rsp_t mgmt_rsp,
  // power-down sources
  input wire logic channel_powerdown_n,
  input wire logic global_powerdown,
  // controls to the analog side
  output lmc_pkg::lmc_pll_t pll,
  output lmc_pkg::lmc_lane_t [lmc_pkg::LMC_LANES-1:0] lanes
);
  import lmc_pkg::*;

  // ****************************************************************
  // access decode
  // ****************************************************************
  lmc_state_t st;
  lmc_state_t next_st;
  logic dev_hit;
  lmc_lreg_t lreg;
  logic [LMC_SEL_MSB-LMC_SEL_LSB:0] lane_mask;
  logic [LMC_LANES-1:0] lane_wr;
  lmc_lane_t sel_lane;

  assign dev_hit = mgmt_req.dev == LMC_DEV_ADDR;
  assign lane_mask = st.ctrl1[LMC_SEL_MSB:LMC_SEL_LSB];

  // (RULE11) lane register offsets decoded
  always_comb begin
    if (mgmt_req.addr == LMC_REG_CTRL2) begin
      lreg = LMC_LREG_CTRL2;
    end else if (mgmt_req.addr == LMC_REG_CTRL3) begin
      lreg = LMC_LREG_CTRL3;
    end else if (mgmt_req.addr == LMC_REG_CHCTL) begin
      lreg = LMC_LREG_CHCTL;
    end else begin
      lreg = LMC_LREG_NONE;
    end
  end

  // ****************************************************************
  // lane banks
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < LMC_LANES; gi++) begin : g_lane
      // (RULE1) per-lane write gate
      // (RULE2) all masked lanes together; (RULE13) empty mask
      assign lane_wr[gi] = mgmt_req.wr && dev_hit &&
                           (lreg != LMC_LREG_NONE) && lane_mask[gi];
      lmc_lane_bank u_bank (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(lane_wr[gi]),
        .wsel(lreg),
        .wdata(mgmt_req.wdata),
        .settings(lanes[gi])
      );
      a_lane_wr_hit: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_n)
        (lane_wr[gi] && lreg == LMC_LREG_CTRL2) |=>
        lanes[gi].ctrl2 == $past(mgmt_req.wdata))
        else $error("masked lane missed a write");
      a_lane_wr_chctl: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        (lane_wr[gi] && lreg == LMC_LREG_CHCTL) |=>
        lanes[gi].chctl == $past(mgmt_req.wdata))
        else $error("masked lane missed a channel write");
      a_lane_wr_skip: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        (mgmt_req.wr && !lane_mask[gi]) |=> $stable(lanes[gi]))
        else $error("unmasked lane changed on write");
      a_lane_other_dev: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_n)
        (mgmt_req.wr && !dev_hit) |=> $stable(lanes[gi]))
        else $error("lane took a foreign write");
      a_lane_rst: assert property ( // RULE11
        @(posedge clk) $rose(rst_n) |-> lanes[gi].ctrl2 == LMC_CTRL2_RST)
        else $error("lane register reset value wrong");
    end
  endgenerate

  // (RULE3) one-hot lane read select
  always_comb begin
    sel_lane = '{ctrl2: LMC_RD_NONE, ctrl3: LMC_RD_NONE,
                 chctl: LMC_RD_NONE};
    for (int i = 0; i < LMC_LANES; i++) begin
      if (lane_mask == (LMC_SEL_MSB-LMC_SEL_LSB+1)'(1 << i)) begin
        sel_lane = lanes[i];
      end
    end
  end

  // ****************************************************************
  // register state
  // ****************************************************************
  always_comb begin
    next_st = st;
    // pin passes three flops; only stages two and three are compared
    next_st.pd_sync = {st.pd_sync[1:0], channel_powerdown_n};
    if (st.pd_sync[1] == st.pd_sync[2]) begin
      next_st.pd_n_level = st.pd_sync[2];
    end
    // (RULE10) whole word stored, reserved bits included
    if (mgmt_req.wr && dev_hit && mgmt_req.addr == LMC_REG_CTRL1) begin
      next_st.ctrl1 = mgmt_req.wdata;
    end
    next_st.rsp.valid = mgmt_req.rd;
    if (mgmt_req.rd) begin
      // (RULE4) non-one-hot mask reads back zero
      if (!dev_hit) begin
        next_st.rsp.data = LMC_RD_NONE;
      end else if (mgmt_req.addr == LMC_REG_CTRL1) begin
        next_st.rsp.data = st.ctrl1;
      end else if (lreg == LMC_LREG_CTRL2) begin
        next_st.rsp.data = sel_lane.ctrl2;
      end else if (lreg == LMC_LREG_CTRL3) begin
        next_st.rsp.data = sel_lane.ctrl3;
      end else if (lreg == LMC_LREG_CHCTL) begin
        next_st.rsp.data = sel_lane.chctl;
      end else begin
        next_st.rsp.data = LMC_RD_NONE;
      end
    end
    // (RULE6) enable bit, (RULE7) forced off by either source
    next_st.pll.on = st.ctrl1[LMC_PLL_EN] && st.pd_n_level &&
                     !global_powerdown;
    // (RULE5) loop bandwidth, reserved codes flagged
    next_st.pll.loop_bw = st.ctrl1[LMC_BW_MSB:LMC_BW_LSB];
    next_st.pll.bw_rsvd =
      (st.ctrl1[LMC_BW_MSB:LMC_BW_LSB] != LMC_BW_NO_CLEANER) &&
      (st.ctrl1[LMC_BW_MSB:LMC_BW_LSB] != LMC_BW_CLEANER);
    // (RULE8) multiplier code, (RULE9) factor decode
    next_st.pll.mpy = st.ctrl1[LMC_MPY_MSB:LMC_MPY_LSB];
    next_st.pll.factor_x2 =
      lmc_mpy_factor_x2(st.ctrl1[LMC_MPY_MSB:LMC_MPY_LSB]);
    next_st.pll.mpy_rsvd =
      lmc_mpy_factor_x2(st.ctrl1[LMC_MPY_MSB:LMC_MPY_LSB]) == 8'h00;
  end

  // reset pll outputs off; they follow the register one cycle later
  // (RULE12) control register reset word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{ctrl1: LMC_CTRL1_RST,
              rsp: '{valid: 1'b0, data: LMC_RD_NONE},
              pd_sync: 3'h7,
              pd_n_level: 1'b1,
              pll: '{on: 1'b0, loop_bw: 2'h0, bw_rsvd: 1'b0, mpy: 4'h0,
                     factor_x2: 8'h00, mpy_rsvd: 1'b0}};
    end else begin
      st <= next_st;
    end
  end

  assign mgmt_rsp = st.rsp;
  assign pll = st.pll;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_ctrl1_reset: assert property ( // RULE12
    @(posedge clk) $rose(rst_n) |-> st.ctrl1 == LMC_CTRL1_RST)
    else $error("control register reset value wrong");
  a_ctrl1_write: assert property ( // RULE10
    @(posedge clk) disable iff (!rst_n)
    (mgmt_req.wr && dev_hit && mgmt_req.addr == LMC_REG_CTRL1) |=>
    st.ctrl1 == $past(mgmt_req.wdata))
    else $error("control register write lost bits");
  a_ctrl1_other_dev: assert property ( // RULE12
    @(posedge clk) disable iff (!rst_n)
    (mgmt_req.wr && !dev_hit) |=> $stable(st.ctrl1))
    else $error("control register took a foreign write");
  a_pll_forced_off: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_n)
    (global_powerdown || !st.pd_n_level) |=> !pll.on)
    else $error("pll on during power-down");
  // stages two and three must agree before the level moves
  a_pin_settle: assert property ( // RULE7
    @(posedge clk) disable iff (!rst_n)
    (!st.pd_sync[1] && !st.pd_sync[2]) |=> !st.pd_n_level)
    else $error("settled power-down pin not taken");
  a_pll_enabled: assert property ( // RULE6
    @(posedge clk) disable iff (!rst_n)
    (st.ctrl1[LMC_PLL_EN] && st.pd_n_level && !global_powerdown)
    ##1 (st.ctrl1[LMC_PLL_EN] && st.pd_n_level && !global_powerdown)
    |=> pll.on)
    else $error("pll not on while enabled");
  a_bw_follow: assert property ( // RULE5
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> pll.loop_bw == $past(st.ctrl1[LMC_BW_MSB:LMC_BW_LSB]))
    else $error("loop bandwidth output lags register");
  a_mpy_follow: assert property ( // RULE8
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> pll.mpy == $past(st.ctrl1[LMC_MPY_MSB:LMC_MPY_LSB]))
    else $error("multiplier output lags register");
  a_mpy_fraction: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_n)
    pll.mpy == 4'h7 |-> pll.factor_x2 == 8'd25 && !pll.mpy_rsvd)
    else $error("12.5x code decoded wrong");
  a_mpy_reserved: assert property ( // RULE9
    @(posedge clk) disable iff (!rst_n)
    pll.mpy == 4'h3 |-> pll.mpy_rsvd)
    else $error("reserved multiplier not flagged");
  a_read_lane: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    (mgmt_req.rd && dev_hit && lreg == LMC_LREG_CTRL2 &&
     lane_mask == 4'h4) |=> mgmt_rsp.valid &&
    mgmt_rsp.data == $past(lanes[2].ctrl2))
    else $error("lane 2 read returned other data");
  a_rsp_pulse: assert property ( // RULE3
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> mgmt_rsp.valid == $past(mgmt_req.rd))
    else $error("read response not one cycle after read");
  a_zero_mask: assert property ( // RULE13
    @(posedge clk) disable iff (!rst_n)
    (mgmt_req.wr && lane_mask == 4'h0) |=> $stable(lanes))
    else $error("zero mask write changed a lane");
  a_bw_reset: assert property ( // RULE5
    @(posedge clk) $rose(rst_n) |-> ##1 pll.loop_bw == LMC_BW_NO_CLEANER)
    else $error("loop bandwidth reset wrong");

endmodule

// file: dv/tb.sv
// tb: self-checking bench for the lane-masked serdes control register.
// assumes lmc_pkg is compiled first; drives the register port directly.
`timescale 1ns/100ps
module tb;
  import lmc_pkg::*;
  logic clk;
  logic rst_n;
  lmc_req_t req;
  lmc_rsp_t rsp;
  logic pd_n;
  logic gpd;
  lmc_pll_t pll;
  lmc_lane_t [LMC_LANES-1:0] lanes;
  int errors;
  int n_tests;
  logic [15:0] rdat;

  lmc_lane_ctrl i_lmc_lane_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .mgmt_req(req),
    .mgmt_rsp(rsp),
    .channel_powerdown_n(pd_n),
    .global_powerdown(gpd),
    .pll(pll),
    .lanes(lanes)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req = '{wr: 1'b1, rd: 1'b0, dev: LMC_DEV_ADDR, addr: a, wdata: d};
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    req = '{wr: 1'b0, rd: 1'b1, dev: LMC_DEV_ADDR, addr: a,
            wdata: 16'h0000};
    tick(1);
    req.rd = 1'b0;
    // response is due exactly one edge after the read edge
    chk("rsp_valid", 16'h0001, {15'h0000, rsp.valid});
    d = rsp.data;
    tick(1);
    chk("rsp_valid_drop", 16'h0000, {15'h0000, rsp.valid});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    tick(2);
    for (int i = 0; i < LMC_LANES; i++) begin
      chk("lane_ctrl2", 16'hdc04, lanes[i].ctrl2);
      chk("lane_ctrl3", 16'h0000, lanes[i].ctrl3);
    end
    chk("pll_on", 16'h0001, {15'h0000, pll.on});
    chk("loop_bw", 16'h0001, {14'h0000, pll.loop_bw});
    chk("mpy", 16'h0005, {12'h000, pll.mpy});
    chk("factor", 16'h0014, {8'h00, pll.factor_x2});
    rd(LMC_REG_CTRL1, rdat);
    chk("ctrl1", 16'hf115, rdat);
    $display("test reset done");
  endtask

  task automatic t_mask;
    logic [3:0] m;
    wr(LMC_REG_CTRL1, 16'h3115);
    wr(LMC_REG_CTRL2, 16'h1234);
    for (int i = 0; i < LMC_LANES; i++)
      chk("ctrl2_0011", i < 2 ? 16'h1234 : 16'hdc04, lanes[i].ctrl2);
    wr(LMC_REG_CTRL1, 16'h0115);
    wr(LMC_REG_CTRL2, 16'hbeef);
    for (int i = 0; i < LMC_LANES; i++)
      chk("ctrl2_0000", i < 2 ? 16'h1234 : 16'hdc04, lanes[i].ctrl2);
    wr(LMC_REG_CTRL1, 16'h4115);
    wr(LMC_REG_CTRL3, 16'h00a5);
    wr(LMC_REG_CHCTL, 16'h005a);
    for (int i = 0; i < LMC_LANES; i++) begin
      chk("ctrl3_0100", i == 2 ? 16'h00a5 : 16'h0000, lanes[i].ctrl3);
      chk("chctl_0100", i == 2 ? 16'h005a : 16'h0000, lanes[i].chctl);
    end
    for (int i = 0; i < LMC_LANES; i++) begin
      m = 4'(1 << i);
      wr(LMC_REG_CTRL1, {m, 12'h115});
      rd(LMC_REG_CTRL2, rdat);
      chk("rd_ctrl2", i < 2 ? 16'h1234 : 16'hdc04, rdat);
      rd(LMC_REG_CTRL3, rdat);
      chk("rd_ctrl3", i == 2 ? 16'h00a5 : 16'h0000, rdat);
      rd(LMC_REG_CHCTL, rdat);
      chk("rd_chctl", i == 2 ? 16'h005a : 16'h0000, rdat);
    end
    $display("test mask done");
  endtask

  task automatic t_codes;
    // factor doubled so 12.5x is whole; 0 marks a reserved code
    logic [7:0] fx [16] = '{8'd8, 8'd10, 8'd12, 8'd0, 8'd16, 8'd20,
      8'd24, 8'd25, 8'd30, 8'd40, 8'd50, 8'd0, 8'd0, 8'd100, 8'd130, 8'd0};
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(LMC_REG_CTRL1, {4'h1, 2'b00, c[1:0], 4'h1, c});
      tick(1);
      chk("factor", {8'h00, fx[i]}, {8'h00, pll.factor_x2});
      chk("mpy_code", {12'h000, c}, {12'h000, pll.mpy});
      chk("mpy_rsvd", {15'h0000, fx[i] == 8'd0},
          {15'h0000, pll.mpy_rsvd});
      chk("loop_bw", {14'h0000, c[1:0]}, {14'h0000, pll.loop_bw});
      chk("bw_rsvd", {15'h0000, c[1:0] == 2'b00 || c[1:0] == 2'b11},
          {15'h0000, pll.bw_rsvd});
    end
    $display("test codes done");
  endtask

  task automatic t_rsvd;
    wr(LMC_REG_CTRL1, 16'h1df5);
    rd(LMC_REG_CTRL1, rdat);
    chk("ctrl1_rsvd", 16'h1df5, rdat);
    req = '{wr: 1'b1, rd: 1'b0, dev: 5'h01, addr: LMC_REG_CTRL1,
            wdata: 16'h0000};
    tick(1);
    req.wr = 1'b0;
    tick(1);
    rd(LMC_REG_CTRL1, rdat);
    chk("ctrl1_otherdev", 16'h1df5, rdat);
    rd(16'h0020, rdat);
    chk("unmapped", LMC_RD_NONE, rdat);
    $display("test reserved done");
  endtask

  task automatic t_pd;
    wr(LMC_REG_CTRL1, 16'h1115);
    tick(1);
    chk("on_base", 16'h0001, {15'h0000, pll.on});
    // pin passes a 3-flop synchronizer, so allow its latency
    pd_n = 1'b0;
    tick(6);
    chk("on_pin", 16'h0000, {15'h0000, pll.on});
    pd_n = 1'b1;
    tick(6);
    chk("on_pin_rel", 16'h0001, {15'h0000, pll.on});
    gpd = 1'b1;
    tick(2);
    chk("on_global", 16'h0000, {15'h0000, pll.on});
    gpd = 1'b0;
    tick(2);
    chk("on_global_rel", 16'h0001, {15'h0000, pll.on});
    wr(LMC_REG_CTRL1, 16'h1105);
    tick(1);
    chk("on_bit_off", 16'h0000, {15'h0000, pll.on});
    $display("test powerdown done");
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    pd_n = 1'b1;
    gpd = 1'b0;
    req = '0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_mask();
    t_codes();
    t_rsvd();
    t_pd();
    end_of_test();
  end

  // whole run is under two hundred cycles; this is far beyond it
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
